// ===== rtl/alt_master_handshake.v
// Alternate memory bus master handshake with an AHB-Lite register slave.
//
// Our own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`include "alt_master_map.vh"

module alt_master_handshake (
	// Clock and reset.
	input  wire        clk,
	input  wire        reset,
	// AHB-Lite slave.
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Memory controller side.
	input  wire        mem_busy,
	input  wire        refresh_busy,
	input  wire        refresh_request,
	output reg         mem_hold,
	output reg         deferred_refresh,
	// Alternate master pins.
	input  wire        alt_master_request,
	output reg         alt_master_grant,
	output reg         memory_pins_oe
);

	localparam [3:0] ST_DRIVE   = 4'b0001;
	localparam [3:0] ST_DRAIN   = 4'b0010;
	localparam [3:0] ST_GRANTED = 4'b0100;
	localparam [3:0] ST_RESUME  = 4'b1000;

	reg [31:0] gpio_dir_reg;
	reg [31:0] gpio_alt_reg;
	reg [31:0] test_ctrl_reg;
	reg [3:0]  state_reg;
	reg [3:0]  state_next;
	reg [2:0]  req_sync_reg;
	reg        req_level_reg;
	reg        pend_refresh_reg;
	reg        wr_pend_reg;
	reg [7:0]  wr_addr_reg;
	reg        wr_dir_en;
	reg        wr_alt_en;
	reg        wr_test_en;
	reg [31:0] read_word;

	wire       dir_ok;
	wire       alt_ok;
	wire       test_ok;
	wire       mode_on;
	wire       word_access;
	wire       take;

	// mode enable: grant pin out, request pin in, both alternate, and the test enable bit set.
	assign dir_ok  = gpio_dir_reg[`GRANT_PIN_BIT]
		& ~gpio_dir_reg[`REQUEST_PIN_BIT];
	assign alt_ok  = gpio_alt_reg[`GRANT_PIN_BIT]
		& gpio_alt_reg[`REQUEST_PIN_BIT];
	assign test_ok = test_ctrl_reg[`TEST_ENABLE_BIT];
	assign mode_on = dir_ok & alt_ok & test_ok;

	// Only whole-word transfers are decoded.
	assign word_access = (hsize == `HSIZE_WORD);
	assign take        = hsel & hready & htrans[`HTRANS_NONSEQ_BIT]
		& word_access;

	always @(posedge clk) begin
		if (reset) begin
			req_sync_reg <= `SYNC_RESET;
		end else begin
			req_sync_reg <= {req_sync_reg[1:0], alt_master_request};
		end
	end

	// agreement filter.
	// A lone differing sample may be metastable, so it is ignored.
	always @(posedge clk) begin
		if (reset) begin
			req_level_reg <= 1'b0;
		end else if (req_sync_reg[2] == req_sync_reg[1]) begin
			req_level_reg <= req_sync_reg[2];
		end
	end

	// Arbitration state machine.
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_DRIVE: begin
				if (req_level_reg && mode_on)
					state_next = ST_DRAIN;
			end
			ST_DRAIN: begin
				if (!req_level_reg || !mode_on)
					state_next = ST_DRIVE;
				else if (!mem_busy && !refresh_busy)
					state_next = ST_GRANTED;
			end
			ST_GRANTED: begin
				if (!req_level_reg)
					state_next = ST_RESUME;
			end
			ST_RESUME: begin
				if (!pend_refresh_reg && !refresh_busy)
					state_next = ST_DRIVE;
			end
			default: state_next = ST_DRIVE;
		endcase
	end

	// State register.
	always @(posedge clk) begin
		if (reset) begin
			state_reg <= ST_DRIVE;
		end else begin
			state_reg <= state_next;
		end
	end

	// refresh deferred.
	// The device cannot refresh while released, so the request is kept.
	always @(posedge clk) begin
		if (reset) begin
			pend_refresh_reg <= 1'b0;
		end else if (state_reg == ST_GRANTED && refresh_request) begin
			pend_refresh_reg <= 1'b1;
		end else if (state_reg == ST_RESUME && refresh_busy) begin
			pend_refresh_reg <= 1'b0;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			alt_master_grant <= 1'b0;
		end else begin
			alt_master_grant <= (state_next == ST_GRANTED);
		end
	end

	// release pins.
	// Enable and grant switch on one edge, so the bus never has two drivers.
	always @(posedge clk) begin
		if (reset) begin
			memory_pins_oe <= 1'b1;
		end else begin
			memory_pins_oe <= (state_next != ST_GRANTED);
		end
	end

	// stall new work.
	// Held through resume so stalled work waits behind the refresh.
	always @(posedge clk) begin
		if (reset) begin
			mem_hold <= 1'b0;
		end else begin
			mem_hold <= (state_next != ST_DRIVE);
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			deferred_refresh <= 1'b0;
		end else begin
			deferred_refresh <= (state_next == ST_RESUME)
				& (pend_refresh_reg
				| (state_reg == ST_GRANTED & refresh_request));
		end
	end

	// Single-cycle slave; write data only arrives in the data phase,
	// so the address phase is kept for one cycle.
	always @(posedge clk) begin
		if (reset) begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= `ADDR_RESET;
		end else begin
			wr_pend_reg <= take & hwrite;
			wr_addr_reg <= haddr[`DECODE_MSB:0];
		end
	end

	// Write decode.
	always @* begin
		wr_dir_en  = 1'b0;
		wr_alt_en  = 1'b0;
		wr_test_en = 1'b0;
		if (wr_pend_reg) begin
			case (wr_addr_reg)
				`REG_GPIO_DIR:  wr_dir_en  = 1'b1;
				`REG_GPIO_ALT:  wr_alt_en  = 1'b1;
				`REG_TEST_CTRL: wr_test_en = 1'b1;
				default:        wr_dir_en  = 1'b0;
			endcase
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			gpio_dir_reg <= `GPIO_DIR_RESET;
		end else if (wr_dir_en) begin
			gpio_dir_reg <= hwdata;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			gpio_alt_reg <= `GPIO_ALT_RESET;
		end else if (wr_alt_en) begin
			gpio_alt_reg <= hwdata;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			test_ctrl_reg <= `TEST_CTRL_RESET;
		end else if (wr_test_en) begin
			test_ctrl_reg <= hwdata;
		end
	end

	// Read multiplexer; unmapped offsets read as zero.
	always @* begin
		case (haddr[`DECODE_MSB:0])
			`REG_GPIO_DIR:  read_word = gpio_dir_reg;
			`REG_GPIO_ALT:  read_word = gpio_alt_reg;
			`REG_TEST_CTRL: read_word = test_ctrl_reg;
			`REG_STATUS:    read_word = {`STATUS_PAD,
				pend_refresh_reg, req_level_reg,
				mode_on, 1'b0, state_reg};
			default:        read_word = `READ_IDLE;
		endcase
	end

	// Read data stands until the next read.
	always @(posedge clk) begin
		if (reset) begin
			hrdata <= `READ_IDLE;
		end else if (take && !hwrite) begin
			hrdata <= read_word;
		end
	end

	// No wait states and no error response.
	always @(posedge clk) begin
		if (reset) begin
			hreadyout <= 1'b1;
			hresp     <= `HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= `HRESP_OKAY;
		end
	end

endmodule // alt_master_handshake

// ===== rtl/alt_master_map.vh
// Register offsets, field positions and reset values for the bus handover.
`ifndef ALT_MASTER_MAP_VH
`define ALT_MASTER_MAP_VH
`define REG_GPIO_DIR      8'h00
`define REG_GPIO_ALT      8'h04
`define REG_TEST_CTRL     8'h08
`define REG_STATUS        8'h0C
`define GRANT_PIN_BIT     21
`define REQUEST_PIN_BIT   22
`define TEST_ENABLE_BIT   10
`define GPIO_DIR_RESET    32'h0000_0000
`define GPIO_ALT_RESET    32'h0000_0000
`define TEST_CTRL_RESET   32'h0000_0000
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD        3'h2
`define HRESP_OKAY        1'b0
`define DECODE_MSB        7
`define ADDR_RESET        8'h00
`define SYNC_RESET        3'h0
`define STATUS_PAD        24'h00_0000
`define READ_IDLE         32'h0000_0000
`endif

// ===== tb/alt_master_properties.sv
// Checker bound to the bus handover block.
`timescale 1ns/1ns
module alt_master_properties (
	input wire logic clk, reset, mem_busy, refresh_busy, mem_hold,
	input wire logic deferred_refresh, alt_master_request,
	input wire logic alt_master_grant, memory_pins_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	pins_off_a: assert property (alt_master_grant ^ memory_pins_oe)
		else $error("oe");
	drain_first_a: assert property (mem_busy | refresh_busy |=>
		!$rose(alt_master_grant)) else $error("early");
	sync_wait_a: assert property ($rose(alt_master_grant) |->
		$past(alt_master_request, 3)) else $error("sync");
	tenure_held_a: assert property (alt_master_grant &
		alt_master_request |=> alt_master_grant) else $error("drop");
	hold_granted_a: assert property (alt_master_grant |-> mem_hold)
		else $error("hold");
	release_bus_a: assert property (alt_master_grant &
		!alt_master_request |-> ##[1:8] memory_pins_oe) else $error("rel");
	refresh_first_a: assert property (deferred_refresh |->
		mem_hold & memory_pins_oe) else $error("ref");
endmodule // alt_master_properties
bind alt_master_handshake alt_master_properties chk_u (.clk, .reset,
	.mem_busy, .refresh_busy, .mem_hold, .deferred_refresh,
	.alt_master_request, .alt_master_grant, .memory_pins_oe);

// ===== tb/alt_master_partner.sv
// Alternate bus master model.
`timescale 1ns/1ns
module alt_master_partner (
	input wire logic clk, want, grant,
	output logic request, pins_driven
);
	// Asynchronous pin, so it moves off the edge.
	always @(posedge clk) request <= #1 want;
	assign pins_driven = grant & request;
endmodule // alt_master_partner

// ===== tb/alt_master_handshake_bench.sv
// Bench for the bus handover block.
`timescale 1ns/1ns
module alt_master_handshake_bench;
	logic clk = 0, reset = 1, hwrite = 0, mem_busy = 0, want = 0;
	logic refresh_busy = 0, refresh_request = 0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, r;
	wire [31:0] hrdata;
	wire hreadyout, hresp, mem_hold, refr, request, grant, oe;
	int failures = 0, checks_done = 0, cycles = 0;
	always #2 clk = ~clk;
	alt_master_handshake dut_u (.clk, .reset, .hsel(1'h1), .haddr,
		.htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
		.hrdata, .hreadyout, .hresp, .mem_busy, .refresh_busy,
		.refresh_request, .mem_hold, .deferred_refresh(refr),
		.alt_master_request(request), .alt_master_grant(grant),
		.memory_pins_oe(oe));
	alt_master_partner far_u (.clk, .want, .grant, .request,
		.pins_driven());
	function logic [31:0] nx(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function logic [31:0] ex(input logic [7:0] a, input logic [31:0] x);
		return x & 32'hffbf_ffff | (a != 8'h0 ? 32'h0060_0400 : 32'h0020_0000);
	endfunction
	task ck(input string n, input logic [31:0] e, s);
		checks_done++;
		if (s !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hwrite <= w;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		do @(posedge clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		q = hrdata;
	endtask
	task wt(input logic v);
		for (int i = 0; i < 40 && grant !== v; i++) @(negedge clk);
		ck("grant", v, grant);
	endtask
	task end_of_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk) if (++cycles == 2000) begin
		failures++;
		end_of_test;
	end
	initial begin
		r = 32'h0823_c66c;
		repeat (5) @(posedge clk);
		reset <= 1'h0;
		want <= 1'h1;
		repeat (20) @(posedge clk);
		ck("off", 0, grant);
		want <= 1'h0;
		for (int a = 0; a < 12; a += 4) begin
			r = nx(r);
			bus(1, a[7:0], ex(a[7:0], r));
			bus(0, a[7:0], 32'h0);
			ck("reg", ex(a[7:0], r), q);
		end
		mem_busy <= 1'h1;
		want <= 1'h1;
		repeat (12) @(posedge clk);
		ck("busy", 0, grant);
		mem_busy <= 1'h0;
		wt(1);
		ck("oe", 0, oe);
		bus(0, 8'h0c, 32'h0);
		ck("status", 32'h0000_0064, q);
		ck("hresp", 0, hresp);
		@(posedge clk);
		refresh_request <= 1'h1;
		want <= 1'h0;
		wt(0);
		ck("oe", 1, oe);
		repeat (2) @(negedge clk);
		ck("refr", 1, refr);
		@(posedge clk);
		refresh_busy <= 1'h1;
		refresh_request <= 1'h0;
		repeat (4) @(posedge clk);
		refresh_busy <= 1'h0;
		repeat (4) @(negedge clk);
		ck("hold", 0, mem_hold);
		end_of_test;
	end
endmodule // alt_master_handshake_bench
